// File: inc/rsp_link_if.sv
`timescale 1ns/100ps
interface rsp_link_if;
  logic ce;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  modport dev  (input ce, input sclk, input si, output so, output so_oe);
  modport host (output ce, output sclk, output si, input so);
endinterface

// File: inc/rsp_pkg.sv
package rsp_pkg;
  // Core clock
  localparam int CLK_MHZ        = 250;
  localparam int CLK_PERIOD_NS  = 4;
  // Serial framing
  localparam int BYTE_BITS      = 8;
  localparam logic [3:0] FMT_WR_ONE   = 4'h8;
  localparam logic [3:0] FMT_WR_BURST = 4'h0;
  localparam logic [3:0] FMT_RD_ONE   = 4'hC;
  localparam logic [3:0] FMT_RD_BURST = 4'h4;
  localparam int FMT_SINGLE_BIT = 3;
  localparam int FMT_READ_BIT   = 2;
  // Carry hold limit and host spacing times
  localparam int HOLD_MAX_S     = 1;
  localparam int HOLD_MAX_CYC   = HOLD_MAX_S * CLK_MHZ * 1_000_000;
  localparam int CE_SETUP_US    = 31;
  localparam int CE_SETUP_CYC   = CE_SETUP_US * CLK_MHZ;
  localparam int CE_GAP_US      = 62;
  localparam int CE_GAP_CYC     = CE_GAP_US * CLK_MHZ;
  // Serial clock made by the host divider, and host byte buffer depth
  localparam int SCLK_PERIOD_NS = 64;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int FIFO_DEPTH     = 8;
  // Host controller register map
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_TXDATA = 4'h4;
  localparam logic [3:0] REG_RXDATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam int CTRL_EN      = 0;
  localparam int CTRL_IDLE_HI = 1;
  localparam int CTRL_SKIP    = 2;
  localparam int ST_CE        = 0;
  localparam int ST_BUSY      = 1;
  localparam int ST_EMPTY     = 2;
  localparam int ST_FULL      = 3;
  localparam int ST_RXVALID   = 4;
  localparam int ST_TIMEOUT   = 5;
  // State machines
  typedef enum logic [1:0] {DS_IGNORE, DS_CMD, DS_WR, DS_RD} rsp_dev_state_t;
  typedef enum logic [2:0] {HS_OFF, HS_GAP, HS_SETUP, HS_WAIT, HS_SHIFT} rsp_host_state_t;
endpackage

// File: verif/rsp_link_chk.sv
`timescale 1ns/100ps
module rsp_link_chk (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  // Link wires
  input wire logic ce,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic       ce_q;
  logic       sclk_q;
  logic       mode_hi;
  logic       samp;
  logic       drv;
  logic [2:0] bits;
  logic [3:0] since;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  // Sample and drive edges depend on the mode latched at chip enable rise
  assign samp = ce && (mode_hi ? (sclk && !sclk_q) : (!sclk && sclk_q));
  assign drv  = ce && (mode_hi ? (!sclk && sclk_q) : (sclk && !sclk_q));
  // Edge history, bit count in the byte, clocks since the last drive edge
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      ce_q    <= 1'b0;
      sclk_q  <= 1'b0;
      mode_hi <= 1'b0;
      bits    <= 3'h0;
      since   <= 4'hF;
    end else begin
      ce_q    <= ce;
      sclk_q  <= sclk;
      mode_hi <= (ce && !ce_q) ? sclk : mode_hi;
      bits    <= !ce ? 3'h0 : bits + 3'(samp);
      since   <= drv ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
    end
  end
  chk_oe_ce_low: assert property (!ce [*8] |-> !so_oe)
    else $error("data out enabled while chip enable low");
  chk_so_drive_edge: assert property (so_oe && $past(so_oe) && $changed(so) |-> since < 4'h8)
    else $error("data out moved away from a drive edge");
  chk_si_setup: assert property (samp |-> si == $past(si) && si == $past(si, 4))
    else $error("data in not steady at sample edge");
  chk_mode_setup: assert property ($rose(ce) |-> $stable(sclk) ##1 $stable(sclk))
    else $error("clock level moved at chip enable rise");
  chk_half_hi: assert property (ce && !mode_hi && $rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("clock high half not eight clocks");
  chk_half_lo: assert property (ce && mode_hi && $fell(sclk) |-> !sclk [*8] ##1 sclk)
    else $error("clock low half not eight clocks");
  chk_whole_bytes: assert property ($fell(ce) |-> bits == 3'h0)
    else $error("chip enable fell inside a byte");
  chk_oe_boundary: assert property ($rose(so_oe) |-> ce && bits == 3'h0)
    else $error("data out enabled off a byte boundary");
endmodule

// File: verif/rtc_four_wire_serial_port_test.sv
`timescale 1ns/100ps
module rtc_four_wire_serial_port_test;
  import rsp_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        arm = 1'b0;
  logic        carry_in = 1'b0;
  logic        rd_pend = 1'b0;
  logic [7:0]  o_rdata;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [7:0]  reg_rdata = 8'h00;
  logic        carry_out;
  logic [3:0]  addr2;
  logic [7:0]  wdata2;
  logic        we2;
  logic        re2;
  logic        carry2;
  logic        session;
  logic        session2;
  int          cc2 = 0;
  int          r2 = 0;
  logic [7:0]  mem [16];
  logic [7:0]  exp_mem [16];
  logic [15:0] wq [$];
  logic [15:0] rq [$];
  logic [15:0] w2v = 16'h0000;
  logic [7:0]  d;
  int          failures = 0;
  int          tests_run = 0;
  int          cc = 0;
  int          c0;
  int          w2 = 0;
  int          cyc = 0;
  rsp_link_if link ();
  rsp_link_if link2 ();
  rsp_host #(.HALF_CYC(8), .SETUP_CYC(20), .GAP_CYC(20), .MAX_HIGH_CYC(2000)) rsp_host_inst (
    .I_MCLK(clk), .I_RESET_N(rst_n), .LINK(link), .I_ADDR(i_addr), .I_WDATA(i_wdata),
    .I_WR(i_wr), .I_RD(i_rd), .O_RDATA(o_rdata));
  rsp_device #(.HOLD_CYCLES(200)) rsp_device_inst (
    .I_MCLK(clk), .I_RESET_N(rst_n), .LINK(link), .O_REG_ADDR(reg_addr),
    .O_REG_WDATA(reg_wdata), .O_REG_WE(reg_we), .O_REG_RE(reg_re), .I_REG_RDATA(reg_rdata),
    .I_SEC_CARRY(carry_in), .O_SEC_CARRY(carry_out), .O_SESSION(session));
  // Second device faces a bench driver that breaks the host's rules
  rsp_device #(.HOLD_CYCLES(200)) rsp_device_inst_b (
    .I_MCLK(clk), .I_RESET_N(rst_n), .LINK(link2), .O_REG_ADDR(addr2), .O_REG_WDATA(wdata2),
    .O_REG_WE(we2), .O_REG_RE(re2), .I_REG_RDATA(reg_rdata), .I_SEC_CARRY(carry_in),
    .O_SEC_CARRY(carry2), .O_SESSION(session2));
  rsp_link_chk rsp_link_chk_inst (
    .I_MCLK(clk), .I_RESET_N(rst_n), .ce(link.ce), .sclk(link.sclk), .si(link.si),
    .so(link.so), .so_oe(link.so_oe));
  always #2 clk = ~clk;
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Register file behind the device, read data one cycle after the strobe
  always @(posedge clk) begin
    if (reg_we) mem[reg_addr] <= reg_wdata;
    if (reg_re) reg_rdata <= mem[reg_addr];
  end
  // Watcher: every result takes the oldest note; an unplanned result never matches
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_pend <= i_rd && arm;
    if (carry_out) cc <= cc + 1;
    if (we2) w2 <= w2 + 1;
    if (re2) r2 <= r2 + 1;
    if (carry2) cc2 <= cc2 + 1;
    if (we2) w2v <= {4'h0, addr2, wdata2};
    if (reg_we) check({4'h0, reg_addr, reg_wdata}, wq.size() ? wq.pop_front() : 16'hFFFF);
    if (rd_pend) check({8'h00, o_rdata}, rq.size() ? rq.pop_front() : 16'hFFFF);
    if (cyc == 40000) failures++;
    if (cyc == 40000) report_and_stop();
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic chk, output logic [7:0] v);
    @(posedge clk);
    i_addr <= a;
    i_rd <= 1'b1;
    arm <= chk;
    @(posedge clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic wait_st(input int b, input logic v);
    logic [7:0] s;
    s = {8{~v}};
    for (int n = 0; n < 2000 && s[b] !== v; n++) rd(REG_STATUS, 1'b0, s);
    if (s[b] !== v) failures++;
  endtask
  // One serial byte; the byte caught from the device is checked when chk is set
  task automatic send(input logic [7:0] b, input logic chk, input logic [7:0] e);
    logic [7:0] s;
    wr(REG_TXDATA, b);
    wait_st(ST_RXVALID, 1'b1);
    if (chk) rq.push_back({8'h00, e});
    rd(REG_RXDATA, chk, s);
  endtask
  task automatic put(input logic [3:0] a, input logic [7:0] v);
    wq.push_back({4'h0, a, v});
    exp_mem[a] = v;
  endtask
  task automatic open(input logic m);
    wr(REG_CTRL, 8'(1 << CTRL_EN | 1 << CTRL_SKIP | m << CTRL_IDLE_HI));
    wait_st(ST_CE, 1'b1);
    repeat (8) @(posedge clk);
  endtask
  task automatic close();
    wr(REG_CTRL, 8'(1 << CTRL_SKIP));
    wait_st(ST_CE, 1'b0);
    repeat (8) @(posedge clk);
  endtask
  task automatic pulse();
    carry_in <= 1'b1;
    @(posedge clk);
    carry_in <= 1'b0;
  endtask
  // Bench bit driver for the second link, top n bits of b
  task automatic bang(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      link2.sclk <= 1'b1;
      link2.si <= b[i];
      repeat (8) @(posedge clk);
      link2.sclk <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  initial begin
    link2.ce = 1'b0;
    link2.sclk = 1'b0;
    link2.si = 1'b0;
    void'($urandom(32'h3347));
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'($urandom);
      exp_mem[i] = mem[i];
    end
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    // Burst write from E wraps to 0
    open(1'b0);
    send(8'hE0, 1'b0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      put(4'(14 + i), d);
      send(d, 1'b0, 8'h00);
    end
    close();
    // Burst read from F in the other clock mode
    open(1'b1);
    send(8'hF4, 1'b0, 8'h00);
    for (int i = 0; i < 3; i++) send(8'h00, 1'b1, exp_mem[4'(15 + i)]);
    close();
    // Read, write, read back chained in one session, then an undefined format
    open(1'b0);
    send(8'hFC, 1'b0, 8'h00);
    send(8'h00, 1'b1, exp_mem[15]);
    send(8'h78, 1'b0, 8'h00);
    d = 8'($urandom);
    put(4'h7, d);
    send(d, 1'b0, 8'h00);
    send(8'h7C, 1'b0, 8'h00);
    send(8'h00, 1'b1, d);
    send(8'h31, 1'b0, 8'h00);
    send(8'h58, 1'b0, 8'h00);
    close();
    // Fill the buffer while disabled; the ninth push is refused
    wr(REG_CTRL, 8'(1 << CTRL_SKIP));
    wr(REG_TXDATA, 8'h30);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      if (i < 7) put(4'(3 + i), d);
      wr(REG_TXDATA, d);
    end
    rq.push_back(16'(1 << ST_FULL));
    rd(REG_STATUS, 1'b1, d);
    open(1'b0);
    for (int n = 0; n < 3000 && wq.size() != 0; n++) @(posedge clk);
    close();
    rq.push_back(16'(1 << ST_EMPTY | 1 << ST_RXVALID));
    rd(REG_STATUS, 1'b1, d);
    // Carry held in a session, let through on close, or after the hold limit
    open(1'b0);
    c0 = cc;
    check(16'(session), 16'h0001);
    pulse();
    repeat (30) @(posedge clk);
    check(16'(cc - c0), 16'h0000);
    close();
    check(16'(cc - c0), 16'h0001);
    check(16'(session), 16'h0000);
    open(1'b0);
    pulse();
    repeat (150) @(posedge clk);
    check(16'(cc - c0), 16'h0001);
    repeat (80) @(posedge clk);
    check(16'(cc - c0), 16'h0002);
    close();
    pulse();
    repeat (6) @(posedge clk);
    check(16'(cc - c0), 16'h0003);
    // Second link: chip enable dropped after five bits, then a clean write
    link2.ce <= 1'b1;
    repeat (8) @(posedge clk);
    check(16'(session2), 16'h0001);
    bang(8'hFF, 5);
    link2.ce <= 1'b0;
    repeat (16) @(posedge clk);
    link2.ce <= 1'b1;
    repeat (8) @(posedge clk);
    bang(8'h28, 8);
    bang(8'h5A, 8);
    repeat (16) @(posedge clk);
    link2.ce <= 1'b0;
    repeat (16) @(posedge clk);
    check(16'(w2), 16'h0001);
    check(w2v, 16'h025A);
    check(16'(r2), 16'h0000);
    check(16'(cc2), 16'h0003);
    report_and_stop();
  end
endmodule

// File: verilog/rsp_device.sv
// What this block and the host do
// RL1: Chip enable rise samples clock level, picks mode
// RL2: Clock high: drive falling, sample rising; else reverse
// RL3: Transfer spans chip enable high, whole bytes
// RL4: Command byte: upper nibble address, lower format
// RL5: Every byte shifted most significant bit first
// RL6: Format 8h writes one byte, then new command
// RL7: Format 0h burst writes, pointer wraps F to 0
// RL8: Format Ch reads one byte, then new command
// RL9: Format 4h burst reads, pointer wraps F to 0
// RL10: Single reads and writes chain in one session
// RL11: Seconds carry held while chip enable high
// RL12: Held carry released after one second anyway
// RL13: Host keeps chip enable high whole session
// RL14: Host keeps chip enable high under one second
// RL15: Host waits 31 us before time access
// RL16: Host keeps chip enable low 62 us
// RL17: Host may skip waits when carry-free
// RL18: Data out driven only for read data bytes
`timescale 1ns/100ps
module rsp_device #(
  parameter int HOLD_CYCLES = rsp_pkg::HOLD_MAX_CYC
) (
  // Clock and reset
  input  wire logic       I_MCLK,
  input  wire logic       I_RESET_N,
  // Serial link
  rsp_link_if.dev         LINK,
  // Time-keeping register port
  output logic [3:0]      O_REG_ADDR,
  output logic [7:0]      O_REG_WDATA,
  output logic            O_REG_WE,
  output logic            O_REG_RE,
  input  wire logic [7:0] I_REG_RDATA,
  // Seconds carry gate
  input  wire logic       I_SEC_CARRY,
  output logic            O_SEC_CARRY,
  output logic            O_SESSION
);
  import rsp_pkg::*;

  generate
    if (HOLD_CYCLES < 2) begin : g_bad_hold
      $error("HOLD_CYCLES must be at least 2");
    end
  endgenerate

  logic [2:0]     sync1;
  logic [2:0]     sync2;
  logic [2:0]     sync3;
  logic [2:0]     lvl;
  logic [2:0]     lvl_d;
  logic           ce;
  logic           sck;
  logic           sdi;
  logic           ce_rise;
  logic           idle_hi;
  logic           drive_edge;
  logic           sample_edge;
  rsp_dev_state_t state;
  logic [2:0]     bit_cnt;
  logic [7:0]     rx;
  logic [7:0]     next_rx;
  logic [3:0]     ptr;
  logic [3:0]     fmt;
  logic           rd_pend;
  logic [7:0]     tx;
  logic           so;
  logic           so_oe;
  logic           pending;
  logic [31:0]    hold_cnt;
  logic           release_now;

  // Three stages on ce, sclk, si; a level is taken once stages two and three agree
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      lvl   <= 3'h0;
      lvl_d <= 3'h0;
    end else begin
      sync1 <= {LINK.ce, LINK.sclk, LINK.si};
      sync2 <= sync1;
      sync3 <= sync2;
      lvl   <= (sync2 & sync3) | (lvl & (sync2 | sync3));
      lvl_d <= lvl;
    end
  end

  assign ce      = lvl[2];
  assign sck     = lvl[1];
  assign sdi     = lvl[0];
  assign ce_rise = ce & ~lvl_d[2];
  assign next_rx = {rx[6:0], sdi}; // see RL5

  // Edge roles follow the mode latched at chip enable rise
  assign drive_edge  = ce & ~ce_rise & (idle_hi ? (~sck & lvl_d[1]) : (sck & ~lvl_d[1])); // see RL2
  assign sample_edge = ce & ~ce_rise & (idle_hi ? (sck & ~lvl_d[1]) : (~sck & lvl_d[1])); // see RL2

  // Clock level at chip enable rise fixes the timing mode for the session
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      idle_hi <= 1'b0;
    end else if (ce_rise) begin
      idle_hi <= sck; // see RL1
    end
  end

  // Byte framing and command decoding
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      state   <= DS_IGNORE;
      bit_cnt <= 3'h0;
      rx      <= 8'h00;
      ptr     <= 4'h0;
      fmt     <= 4'h0;
    end else if (!ce) begin
      state   <= DS_IGNORE; // see RL3
      bit_cnt <= 3'h0;
    end else if (ce_rise) begin
      state   <= DS_CMD; // see RL3
      bit_cnt <= 3'h0;
    end else if (sample_edge) begin
      rx      <= next_rx;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        case (state)
          DS_CMD: begin
            ptr <= next_rx[7:4]; // see RL4
            fmt <= next_rx[3:0]; // see RL4
            // Codes outside the four formats leave the session idle
            if (next_rx[1:0] != 2'h0) begin
              state <= DS_IGNORE;
            end else if (next_rx[FMT_READ_BIT]) begin
              state <= DS_RD;
            end else begin
              state <= DS_WR;
            end
          end
          DS_WR, DS_RD: begin
            if (fmt[FMT_SINGLE_BIT]) begin
              state <= DS_CMD; // see RL6 RL8 RL10
            end else begin
              ptr <= ptr + 4'h1; // see RL7 RL9
            end
          end
          default: state <= DS_IGNORE;
        endcase
      end
    end
  end

  // Register port strobes: write after a data byte, read ahead of each read byte
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      O_REG_ADDR  <= 4'h0;
      O_REG_WDATA <= 8'h00;
      O_REG_WE    <= 1'b0;
      O_REG_RE    <= 1'b0;
      rd_pend     <= 1'b0;
    end else begin
      O_REG_WE <= 1'b0;
      O_REG_RE <= 1'b0;
      rd_pend  <= O_REG_RE;
      if (ce && !ce_rise && sample_edge && bit_cnt == 3'h7) begin
        if (state == DS_WR) begin
          O_REG_WE    <= 1'b1; // see RL6 RL7
          O_REG_ADDR  <= ptr;
          O_REG_WDATA <= next_rx;
        end else if (state == DS_CMD && next_rx[1:0] == 2'h0 && next_rx[FMT_READ_BIT]) begin
          O_REG_RE   <= 1'b1; // see RL8 RL9
          O_REG_ADDR <= next_rx[7:4];
        end else if (state == DS_RD && !fmt[FMT_SINGLE_BIT]) begin
          O_REG_RE   <= 1'b1; // see RL9
          O_REG_ADDR <= ptr + 4'h1;
        end
      end
    end
  end

  // Serial output; enabled only while a read byte is being returned
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      tx    <= 8'h00;
      so    <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_oe <= ce && !ce_rise && state == DS_RD; // see RL18
      if (rd_pend) begin
        tx <= I_REG_RDATA;
      end else if (drive_edge && state == DS_RD) begin
        so <= tx[7]; // see RL5 RL2
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  assign LINK.so    = so;
  assign LINK.so_oe = so_oe;

  // A carry arriving as the held one leaves is kept; one arriving while a carry is already held merges with it
  assign release_now = pending && (!ce || hold_cnt == 32'(HOLD_CYCLES - 1)); // see RL11 RL12

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      pending     <= 1'b0;
      hold_cnt    <= 32'h0;
      O_SEC_CARRY <= 1'b0;
      O_SESSION   <= 1'b0;
    end else begin
      O_SESSION   <= ce;
      O_SEC_CARRY <= release_now; // see RL11
      if (release_now) begin
        pending  <= I_SEC_CARRY;
        hold_cnt <= 32'h0;
      end else begin
        if (I_SEC_CARRY) begin
          pending <= 1'b1;
        end
        if (pending && ce) begin
          hold_cnt <= hold_cnt + 32'h1; // see RL12
        end
      end
    end
  end
endmodule

// File: verilog/rsp_host.sv
`timescale 1ns/100ps
module rsp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(D);

  generate
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
      $error("FIFO depth must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign o_ready = count != CNT_FULL;
  assign o_valid = count != '0;
  assign o_data  = mem[rd_ptr];
  assign push    = i_valid && o_ready;
  assign pop     = i_ready && o_valid;

  // Storage has no reset; only pointers and count carry state
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

module rsp_host #(
  parameter int HALF_CYC     = rsp_pkg::SCLK_HALF_CYC,
  parameter int SETUP_CYC    = rsp_pkg::CE_SETUP_CYC,
  parameter int GAP_CYC      = rsp_pkg::CE_GAP_CYC,
  parameter int MAX_HIGH_CYC = rsp_pkg::HOLD_MAX_CYC - 1
) (
  // Clock and reset
  input  wire logic       I_MCLK,
  input  wire logic       I_RESET_N,
  // Serial link
  rsp_link_if.host        LINK,
  // Software register port
  input  wire logic [3:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic [7:0]      O_RDATA
);
  import rsp_pkg::*;

  generate
    if (HALF_CYC < 6 || SETUP_CYC < 1 || GAP_CYC < 1 || MAX_HIGH_CYC < 2) begin : g_bad
      $error("Host timing parameters out of range");
    end
  endgenerate

  rsp_host_state_t state;
  logic [7:0]      ctrl;
  logic [2:0]      so_sync;
  logic            so_lvl;
  logic [31:0]     cnt;
  logic [31:0]     hi_cnt;
  logic            timeout;
  logic            to_flag;
  logic            ce;
  logic            sclk;
  logic            si;
  logic            phase;
  logic [2:0]      bit_cnt;
  logic [7:0]      tx;
  logic [7:0]      rx;
  logic [7:0]      rx_data;
  logic            rx_done;
  logic [1:0]      cap;
  logic            rx_valid;
  logic            fifo_push;
  logic            fifo_in_ready;
  logic            fifo_valid;
  logic            fifo_pop;
  logic [7:0]      fifo_data;

  assign fifo_push = I_WR && I_ADDR == REG_TXDATA;
  assign fifo_pop  = state == HS_WAIT && ctrl[CTRL_EN] && !timeout;
  assign timeout   = ce && hi_cnt == 32'(MAX_HIGH_CYC - 1); // see RL14

  // Bytes queue here; a write while full is dropped and shows as full
  rsp_fifo #(.W(BYTE_BITS), .D(FIFO_DEPTH)) u_fifo (
    .i_clk     (I_MCLK),
    .i_reset_n (I_RESET_N),
    .i_valid   (fifo_push),
    .o_ready   (fifo_in_ready),
    .i_data    (I_WDATA),
    .o_valid   (fifo_valid),
    .i_ready   (fifo_pop),
    .o_data    (fifo_data)
  );

  // Serial data out from the device crosses in through three stages
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      so_sync <= 3'h0;
      so_lvl  <= 1'b0;
    end else begin
      so_sync <= {so_sync[1:0], LINK.so};
      if (so_sync[1] == so_sync[2]) begin
        so_lvl <= so_sync[1];
      end
    end
  end

  // Chip enable high time watchdog
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N || !ce) begin
      hi_cnt <= 32'h0;
    end else begin
      hi_cnt <= hi_cnt + 32'h1;
    end
  end

  // Session sequencer and bit shifter
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      state   <= HS_OFF;
      ce      <= 1'b0;
      sclk    <= 1'b0;
      si      <= 1'b0;
      cnt     <= 32'h0;
      phase   <= 1'b0;
      bit_cnt <= 3'h0;
      tx      <= 8'h00;
      rx      <= 8'h00;
      rx_data <= 8'h00;
      rx_done <= 1'b0;
      cap     <= 2'h0;
    end else begin
      rx_done <= 1'b0;
      // The device answer needs about ten clocks through both synchronisers,
      // longer than one clock half, so each bit is taken two clocks after the half ends
      cap <= {cap[0], 1'b0};
      if (cap[1]) begin
        rx <= {rx[6:0], so_lvl}; // see RL5
        if (bit_cnt == 3'h0) begin
          rx_data <= {rx[6:0], so_lvl}; // see RL8 RL9
          rx_done <= 1'b1;
        end
      end
      if (timeout) begin
        ce    <= 1'b0;
        state <= HS_GAP;
        cnt   <= 32'h0;
      end else begin
        case (state)
          HS_OFF: begin
            sclk <= ctrl[CTRL_IDLE_HI]; // see RL1
            if (ctrl[CTRL_EN] && sclk == ctrl[CTRL_IDLE_HI]) begin
              ce    <= 1'b1; // see RL3
              state <= HS_SETUP;
              cnt   <= 32'h0;
            end
          end
          HS_GAP: begin
            cnt <= cnt + 32'h1;
            if (ctrl[CTRL_SKIP] || cnt == 32'(GAP_CYC - 1)) begin
              state <= HS_OFF; // see RL16 RL17
            end
          end
          HS_SETUP: begin
            cnt <= cnt + 32'h1;
            if (ctrl[CTRL_SKIP] || cnt == 32'(SETUP_CYC - 1)) begin
              state <= HS_WAIT; // see RL15 RL17
            end
          end
          HS_WAIT: begin
            // Disabling drops chip enable only between bytes; the watchdog timeout can drop it mid-byte
            if (!ctrl[CTRL_EN]) begin
              ce    <= 1'b0; // see RL13
              state <= HS_GAP;
              cnt   <= 32'h0;
            end else if (fifo_valid) begin
              tx      <= fifo_data;
              state   <= HS_SHIFT;
              cnt     <= 32'h0;
              phase   <= 1'b0;
              bit_cnt <= 3'h0;
            end
          end
          HS_SHIFT: begin
            cnt <= cnt + 32'h1;
            if (cnt == 32'(HALF_CYC - 1)) begin
              cnt   <= 32'h0;
              phase <= ~phase;
              if (!phase) begin
                sclk <= ~ctrl[CTRL_IDLE_HI]; // see RL2
                si   <= tx[7]; // see RL5
                tx   <= {tx[6:0], 1'b0};
              end else begin
                sclk    <= ctrl[CTRL_IDLE_HI];
                cap[0]  <= 1'b1;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                  state <= HS_WAIT; // see RL4 RL6
                end
              end
            end
          end
          default: state <= HS_OFF;
        endcase
      end
    end
  end

  assign LINK.ce   = ce;
  assign LINK.sclk = sclk;
  assign LINK.si   = si;

  // Control, sticky flags and read data; a set in the clearing cycle wins
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      ctrl     <= CTRL_RST;
      rx_valid <= 1'b0;
      to_flag  <= 1'b0;
      O_RDATA  <= 8'h00;
    end else begin
      if (I_WR && I_ADDR == REG_CTRL) begin
        ctrl    <= {5'h00, I_WDATA[2:0]};
        to_flag <= 1'b0;
      end
      if (timeout) begin
        ctrl[CTRL_EN] <= 1'b0; // see RL14
        to_flag       <= 1'b1;
      end
      if (rx_done) begin
        rx_valid <= 1'b1;
      end else if (I_RD && I_ADDR == REG_RXDATA) begin
        rx_valid <= 1'b0;
      end
      O_RDATA <= 8'h00;
      if (I_RD) begin
        case (I_ADDR)
          REG_CTRL:   O_RDATA <= ctrl;
          REG_RXDATA: O_RDATA <= rx_data;
          REG_STATUS: O_RDATA <= {2'h0, to_flag, rx_valid, ~fifo_in_ready, ~fifo_valid,
                                  state == HS_SHIFT, ce};
          default:    O_RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule
